// file: src/fae_defs.vh
// Constants for the flash converter encoder and output stage
`ifndef FAE_DEFS_VH
`define FAE_DEFS_VH
`define FAE_DATA_WIDTH 8
`define FAE_LEVEL_COUNT 255
`define FAE_CMP_COUNT 256
`define FAE_GROUP_SIZE 16
`define FAE_ZERO_WORD 8'h00
`define FAE_FULL_WORD 8'hFF
`define FAE_CLK_PERIOD_NS 50
`define FAE_MIN_BALANCE_NS 20
`define FAE_MIN_SAMPLE_NS 25
`define FAE_MAX_SAMPLE_NS 5000
`define FAE_MIN_BALANCE_CYC ((`FAE_MIN_BALANCE_NS + `FAE_CLK_PERIOD_NS - 1) / `FAE_CLK_PERIOD_NS)
`define FAE_MAX_SAMPLE_CYC (`FAE_MAX_SAMPLE_NS / `FAE_CLK_PERIOD_NS)
`endif

// file: src/fae_thermo_count.v
// Thermometer-to-binary encoder: counts asserted comparator levels
`timescale 1ns/1ns
module fae_thermo_count #(
  parameter LEVELS = 255,
  parameter WIDTH = 8
) (
  // Comparator levels
  input wire [LEVELS-1:0] levels,
  // Binary count
  output reg [WIDTH-1:0] count
);
  integer i;
  // Counting tolerates a bubble in the code better than locating the top bit
  always @* begin
    count = {WIDTH{1'b0}};
    for (i = 0; i < LEVELS; i = i + 1) begin
      count = count + {{(WIDTH-1){1'b0}}, levels[i]};
    end
  end
endmodule // fae_thermo_count

// file: src/fae_encoder_output.v
// Flash converter digital back end: two-phase encoder pipeline and three-state output
`timescale 1ns/1ns
`include "fae_defs.vh"

// Overview of operation
// - Each conversion takes 256 decisions: 255 thermometer levels plus one overrange comparator.
// - Balance phase follows the clock level directly and sample phase is its inverse; the logic runs on clk, paced by convClk edges seen by the phase tracker.
// - The balance phase after a sample captures decisions and encodes a first stage, the next sample phase finishes.
// - Eight data bits and the overrange bit load into output flip-flops on the following falling edge.
// - The overrange flag is set when the input exceeds the top reference less half a step.
// - On overrange every data bit is forced to one as well.
// - Below half a step above the bottom reference the word is all zeros with the flag clear.
// - With the master enable low all data bits and the flag float.
// - With the master enable high the flag is driven and data is driven only while the data enable is low.
// - Each word appears one and a half clock cycles after its sample.
// - The word is valid at the end of the second balance phase after the sampling phase.
// - Exactly one conversion is made per conversion clock period.
module fae_encoder_output #(
  parameter WIDTH = `FAE_DATA_WIDTH,
  parameter LEVELS = `FAE_LEVEL_COUNT
) (
  // System clock and reset
  input wire clk,
  input wire srst,
  // Conversion clock, sampled on clk; high is the balance phase
  input wire convClk,
  // Comparator decisions, bit LEVELS is the overrange comparator
  input wire [LEVELS:0] cmpDecisions,
  // Output enables
  input wire data_output_enable_n,
  input wire master_output_enable,
  // Three-state data bus
  output wire [WIDTH-1:0] conversionBitsOut,
  output wire [WIDTH-1:0] conversionBitsOe,
  // Three-state overrange flag
  output wire overrangeFlagOut,
  output wire overrangeFlagOe,
  // Phase indications and new-word strobe
  output wire balancePhase,
  output wire samplePhase,
  output reg wordStrobe
);
  // Encoder split: groups of levels counted in the balance half, their sum finished in the sample half
  localparam GROUP = `FAE_GROUP_SIZE;
  localparam GROUPS = (LEVELS + GROUP - 1) / GROUP;
  localparam PW = $clog2(GROUP + 1);

  // Phase tracker states, one-hot
  localparam [2:0] PH_WAIT = 3'h1;
  localparam [2:0] PH_SAMPLE = 3'h2;
  localparam [2:0] PH_BALANCE = 3'h4;

  // Phase tracker and its two edge enables
  reg [2:0] phaseState;
  reg [2:0] next_phaseState;
  reg captureEn;
  reg loadEn;

  // Stage one: latched levels and their group counts
  reg [LEVELS-1:0] stageLevels;
  reg stageOver;
  wire [GROUPS*PW-1:0] groupCount;
  reg [GROUPS*PW-1:0] partialCount;
  reg partialOver;

  // Stage two: finished word
  reg [WIDTH-1:0] sumWord;
  reg [WIDTH-1:0] encWord;
  reg encOver;

  // Output flip-flops
  reg [WIDTH-1:0] outWord;
  reg outOver;

  // Bus drive enables
  wire dataDrive;
  wire flagDrive;

  // Loop indices
  integer g;
  genvar gi;
  genvar bi;

  // Bus enable decode shared by the data bits and the flag; the flag ignores the data enable
  function busEnable;
    input masterEn;
    input dataEnN;
    input dataPin;
    begin
      busEnable = masterEn & (~dataPin | ~dataEnN);
    end
  endfunction

  // Overrange saturates the word to all ones, otherwise the level sum stands
  function [WIDTH-1:0] finishWord;
    input over;
    input [WIDTH-1:0] sum;
    begin
      finishWord = over ? {WIDTH{1'b1}} : sum;
    end
  endfunction

  // Two phases from the one conversion clock
  assign balancePhase = convClk;
  assign samplePhase = ~convClk;

  // Phase tracker next state; a high level seen straight after reset is only part of a balance
  // phase, so it is not taken as a capture and the first sample always follows a low level seen in PH_WAIT
  always @* begin
    next_phaseState = phaseState;
    captureEn = 1'b0;
    loadEn = 1'b0;
    case (phaseState)
      PH_WAIT: begin
        if (!convClk) begin
          next_phaseState = PH_SAMPLE;
        end
      end
      PH_SAMPLE: begin
        if (convClk) begin
          next_phaseState = PH_BALANCE;
          captureEn = 1'b1; // End of sample phase, decisions settled
        end
      end
      PH_BALANCE: begin
        if (!convClk) begin
          next_phaseState = PH_SAMPLE;
          loadEn = 1'b1; // Falling edge of the conversion clock
        end
      end
      default: begin
        next_phaseState = PH_WAIT;
      end
    endcase
  end

  // Phase tracker state register
  always @(posedge clk) begin
    if (srst) begin
      phaseState <= PH_WAIT;
    end else begin
      phaseState <= next_phaseState;
    end
  end

  // Decisions latched into the encoder as balance begins
  always @(posedge clk) begin
    if (srst) begin
      stageLevels <= {LEVELS{1'b0}};
      stageOver <= 1'b0;
    end else if (captureEn) begin
      stageLevels <= cmpDecisions[LEVELS-1:0];
      stageOver <= cmpDecisions[LEVELS];
    end
  end

  // First encoding stage: each group counted on its own, so no single adder chain has to
  // span all levels within the short balance half
  generate
    for (gi = 0; gi < GROUPS; gi = gi + 1) begin : gCount
      if ((gi + 1) * GROUP <= LEVELS) begin : gFull
        fae_thermo_count #(
          .LEVELS(GROUP),
          .WIDTH(PW)
        ) i_fae_thermo_count (
          .levels(stageLevels[gi*GROUP +: GROUP]),
          .count(groupCount[gi*PW +: PW])
        );
      end else begin : gTail
        fae_thermo_count #(
          .LEVELS(LEVELS - gi * GROUP),
          .WIDTH(PW)
        ) i_fae_thermo_count (
          .levels(stageLevels[LEVELS-1:gi*GROUP]),
          .count(groupCount[gi*PW +: PW])
        );
      end
    end
  endgenerate

  // Group counts held through the sample phase
  always @(posedge clk) begin
    if (srst) begin
      partialCount <= {(GROUPS*PW){1'b0}};
      partialOver <= 1'b0;
    end else if (loadEn) begin
      partialCount <= groupCount;
      partialOver <= stageOver;
    end
  end

  // Second encoding stage: sum of the group counts, 0 to 255 for in-range inputs
  always @* begin
    sumWord = {WIDTH{1'b0}};
    for (g = 0; g < GROUPS; g = g + 1) begin
      sumWord = sumWord + {{(WIDTH-PW){1'b0}}, partialCount[g*PW +: PW]};
    end
  end

  // Encoding completes as the sample phase ends; overrange forces all ones
  always @(posedge clk) begin
    if (srst) begin
      encWord <= `FAE_ZERO_WORD;
      encOver <= 1'b0;
    end else if (captureEn) begin
      encWord <= finishWord(partialOver, sumWord);
      encOver <= partialOver;
    end
  end

  // Output flip-flops load on the falling edge, one and a half periods after capture,
  // and hold in between
  always @(posedge clk) begin
    if (srst) begin
      outWord <= `FAE_ZERO_WORD;
      outOver <= 1'b0;
      wordStrobe <= 1'b0;
    end else begin
      wordStrobe <= loadEn; // One load per conversion period
      if (loadEn) begin
        outWord <= encWord;
        outOver <= encOver;
      end
    end
  end

  // Three-state control: master enable gates all, data enable gates the data bits only
  assign dataDrive = busEnable(master_output_enable, data_output_enable_n, 1'b1);
  assign flagDrive = busEnable(master_output_enable, data_output_enable_n, 1'b0);
  assign overrangeFlagOut = outOver;
  assign overrangeFlagOe = flagDrive;

  // Per-bit drivers of the data bus
  generate
    for (bi = 0; bi < WIDTH; bi = bi + 1) begin : gBus
      assign conversionBitsOut[bi] = outWord[bi];
      assign conversionBitsOe[bi] = dataDrive;
    end
  endgenerate
endmodule // fae_encoder_output

// file: test/fae_chk_asserts.sv
// Concurrent checks on the encoder output stage ports
`timescale 1ns/1ns
module fae_chk (
  // Clock, reset, conversion clock, enables and the outputs
  input wire clk, input wire srst, input wire convClk, input wire master_output_enable,
  input wire data_output_enable_n, input wire [7:0] conversionBitsOe,
  input wire balancePhase, input wire samplePhase,
  input wire [7:0] conversionBitsOut, input wire overrangeFlagOut, input wire overrangeFlagOe, input wire wordStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  flag_gate_a: assert property (overrangeFlagOe == master_output_enable) else $error("flag enable");
  data_gate_a: assert property (conversionBitsOe == {8{master_output_enable & !data_output_enable_n}})
    else $error("data enable");
  phase_bal_a: assert property (balancePhase == convClk) else $error("balance phase");
  phase_smp_a: assert property (samplePhase == !convClk) else $error("sample phase");
  over_full_a: assert property (overrangeFlagOut |-> &conversionBitsOut) else $error("overrange word");
  word_fall_a: assert property ($changed(conversionBitsOut) |-> !$past(convClk)) else $error("word edge");
  flag_fall_a: assert property ($changed(overrangeFlagOut) |-> !$past(convClk)) else $error("flag edge");
  word_strobe_a: assert property ($changed(conversionBitsOut) |-> ##[0:1] wordStrobe) else $error("word strobe");
  flag_strobe_a: assert property ($changed(overrangeFlagOut) |-> ##[0:1] wordStrobe) else $error("flag strobe");
  strobe_one_a: assert property (wordStrobe |=> !wordStrobe) else $error("strobe width");
  reset_clear_a: assert property ($past(srst) |-> !conversionBitsOut && !overrangeFlagOut) else $error("reset");
endmodule // fae_chk
bind fae_encoder_output fae_chk i_fae_chk (.clk(clk), .srst(srst), .convClk(convClk),
  .master_output_enable(master_output_enable), .data_output_enable_n(data_output_enable_n),
  .conversionBitsOe(conversionBitsOe), .balancePhase(balancePhase), .samplePhase(samplePhase),
  .conversionBitsOut(conversionBitsOut),
  .overrangeFlagOut(overrangeFlagOut), .overrangeFlagOe(overrangeFlagOe), .wordStrobe(wordStrobe));

// file: test/fae_host.sv
// Host model that makes the conversion clock
`timescale 1ns/1ns
module fae_host (input wire clk, output reg convClk = 1'b0);
  // One system cycle per half keeps both halves at or above their minimum
  always @(negedge clk) convClk <= ~convClk;
endmodule // fae_host

// file: test/test_fae_encoder_output.sv
// Self-checking bench for the encoder output stage
`timescale 1ns/1ns
module test_fae_encoder_output;
  reg clk = 0, srst = 1, den = 0, men = 1;
  reg [255:0] cmp = 256'h0;
  wire cc, stb, ov, ovOe;
  wire [7:0] q, qOe;
  integer failures = 0, checks = 0, k;
  always #25 clk = ~clk;
  fae_host i_fae_host (.clk(clk), .convClk(cc));
  fae_encoder_output i_fae_encoder_output (.clk(clk), .srst(srst), .convClk(cc), .cmpDecisions(cmp),
    .data_output_enable_n(den), .master_output_enable(men), .conversionBitsOut(q), .conversionBitsOe(qOe),
    .overrangeFlagOut(ov), .overrangeFlagOe(ovOe), .balancePhase(), .samplePhase(), .wordStrobe(stb));
  // Four-state compare, so an unknown never passes
  task chk(input [31:0] name, input [8:0] seen, input [8:0] exp);
    checks = checks + 1;
    if (seen !== exp) failures = failures + 1;
    if (seen !== exp) $display("Error %0s exp %h seen %h", name, exp, seen);
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Held level count; by the third strobe the pipeline shows it, enables swept meanwhile
  task conv(input [8:0] n);
    @(negedge clk) cmp = n[8] ? ~256'h0 : (256'h1 << n) - 256'h1;
    {men, den} = n[1:0];
    #1 chk("oe", {ovOe, qOe}, {n[1], {8{n[1:0] == 2'h2}}});
    repeat (3) @(posedge stb);
    @(negedge clk) chk("word", {ov, q}, n[8] ? 9'h1ff : n);
  endtask
  // Align to a sample phase: old word just before the load edge, new word right after it
  task latency(input [8:0] prev, input [8:0] n);
    @(posedge cc);
    @(negedge clk) cmp = (256'h1 << n) - 256'h1;
    repeat (4) @(negedge clk);
    chk("lat0", {ov, q}, prev);
    @(negedge clk) chk("lat1", {ov, q}, n);
  endtask
  // Reset in mid run clears a nonzero word and leaves the already clear flag low within two edges
  task resetMid;
    @(negedge clk) srst = 1;
    repeat (2) @(negedge clk);
    chk("rst", {ov, q}, 9'h000);
    srst = 0;
  endtask
  // Cycle ceiling far above the roughly 90 cycles the run needs
  initial begin
    repeat (2000) @(posedge clk);
    failures = failures + 1;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(negedge clk);
    srst = 0;
    for (k = 0; k < 10; k = k + 1) conv(k * 31);
    latency(9'h1ff, 9'h055);
    resetMid;
    conv(9'h0c8);
    tally_and_finish;
  end
endmodule // test_fae_encoder_output
